// *** hdl/sbc_pkg.sv ***
// Constants, field layouts and carrier types for the software and boost control words.
// Assumes a 40 MHz system clock and 16-bit words delivered already deframed.
package sbc_pkg;

  // Clock and time bases
  localparam int unsigned SYS_CLK_KHZ = 40000;
  localparam int unsigned WD_TIMEOUT_US = 5000;
  localparam int unsigned WD_TIMEOUT_CYC = (WD_TIMEOUT_US * SYS_CLK_KHZ) / 1000;

  // Word identification, top three bits
  localparam int unsigned ID_MSB = 15;
  localparam int unsigned ID_LSB = 13;
  localparam logic [2:0] ID_SOFTWARE = 3'h4;
  localparam logic [2:0] ID_BOOST = 3'h3;
  localparam logic [2:0] ID_SLEW = 3'h0;

  // Software word fields
  localparam int unsigned SW_CRC_BIT = 12;
  localparam int unsigned SW_KEY_MSB = 11;
  localparam logic [11:0] KEY_RESET = 12'h555;
  localparam logic [11:0] KEY_KEEPALIVE = 12'h195;

  // Boost control word fields
  localparam int unsigned BC_COMP_BIT = 6;
  localparam int unsigned BC_PHASE_LSB = 4;
  localparam int unsigned BC_RATE_LSB = 2;
  localparam int unsigned BC_CEIL_LSB = 0;

  // Slew word fields
  localparam int unsigned SR_EN_BIT = 12;
  localparam int unsigned SR_CLK_LSB = 3;
  localparam int unsigned SR_STEP_LSB = 0;

  // Switching rate codes and their nominal rates
  localparam logic [1:0] RATE_250K = 2'h0;
  localparam logic [1:0] RATE_410K = 2'h1;
  localparam logic [1:0] RATE_650K = 2'h2;
  localparam logic [1:0] RATE_RESERVED = 2'h3;
  localparam int unsigned RATE_250_KHZ = 250;
  localparam int unsigned RATE_410_KHZ = 410;
  localparam int unsigned RATE_650_KHZ = 650;
  localparam logic [7:0] PER_250_CYC = 8'(SYS_CLK_KHZ / RATE_250_KHZ);
  localparam logic [7:0] PER_410_CYC = 8'(SYS_CLK_KHZ / RATE_410_KHZ);
  localparam logic [7:0] PER_650_CYC = 8'(SYS_CLK_KHZ / RATE_650_KHZ);

  // Phase codes
  localparam logic [1:0] PH_SAME = 2'h0;
  localparam logic [1:0] PH_AB_CD = 2'h1;
  localparam logic [1:0] PH_AC_BD = 2'h2;
  localparam logic [1:0] PH_QUAD = 2'h3;

  localparam int unsigned NUM_CHAN = 4;

  typedef enum logic [1:0] {
    SBC_KIND_OTHER = 2'b00,
    SBC_KIND_SOFTWARE = 2'b01,
    SBC_KIND_BOOST = 2'b10,
    SBC_KIND_SLEW = 2'b11
  } sbc_kind_e;

  typedef struct packed {
    logic [1:0] chan;
    logic [15:0] data;
  } sbc_word_s;

  typedef struct packed {
    logic comp;
    logic [1:0] phase;
    logic [1:0] rate;
    logic [1:0] ceiling;
  } sbc_boost_s;

  typedef struct packed {
    logic enable;
    logic [3:0] clk_sel;
    logic [2:0] step;
  } sbc_slew_s;

  // Values after reset
  localparam sbc_boost_s BOOST_RESET = '{comp: 1'b0, phase: PH_SAME, rate: RATE_410K,
                                         ceiling: 2'h0};
  localparam sbc_slew_s SLEW_RESET = '{enable: 1'b0, clk_sel: 4'h0, step: 3'h0};

endpackage

// *** hdl/sbc_clkgen.sv ***
// Per-channel boost switching clocks, divided from the system clock.
// Assumes rate and phase come from the control register and change rarely.
`timescale 1ns/1ps
`default_nettype none
module sbc_clkgen (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] rate,
  input wire logic [1:0] phase,
  output logic [3:0] chan_clk
);

  logic [7:0] cnt_r;
  logic [7:0] period;
  logic [7:0] quarter;

  function automatic logic [7:0] rate_period(input logic [1:0] code);
    case (code)
      sbc_pkg::RATE_250K: rate_period = sbc_pkg::PER_250_CYC;
      sbc_pkg::RATE_650K: rate_period = sbc_pkg::PER_650_CYC;
      default: rate_period = sbc_pkg::PER_410_CYC;
    endcase
  endfunction

  // Offset of each channel within one period
  function automatic logic [7:0] chan_offset(input logic [1:0] ph, input logic [1:0] ch,
                                             input logic [7:0] q);
    case (ph)
      sbc_pkg::PH_AB_CD: chan_offset = ch[1] ? 8'(q << 1) : 8'h00;
      sbc_pkg::PH_AC_BD: chan_offset = ch[0] ? 8'(q << 1) : 8'h00;
      sbc_pkg::PH_QUAD: chan_offset = 8'(q * ch);
      default: chan_offset = 8'h00;
    endcase
  endfunction

  // Level of one channel clock for a given count, period and offset
  function automatic logic chan_level(input logic [7:0] cnt, input logic [7:0] per,
                                      input logic [7:0] off);
    logic [8:0] shifted;
    shifted = 9'(cnt) + 9'(per) - 9'(off);
    if (shifted >= 9'(per))
      shifted = shifted - 9'(per);
    chan_level = (shifted < 9'(per >> 1));
  endfunction

  assign period = rate_period(rate);
  assign quarter = 8'(period >> 2);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_r <= 8'h00;
    else if (ce)
      cnt_r <= (cnt_r >= period - 8'h01) ? 8'h00 : 8'(cnt_r + 8'h01);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      chan_clk <= 4'h0;
    else if (ce)
      for (int i = 0; i < sbc_pkg::NUM_CHAN; i++)
        chan_clk[i] <= chan_level(cnt_r, period, chan_offset(phase, 2'(i), quarter));
  end

endmodule // sbc_clkgen
`default_nettype wire

// *** hdl/sbc_regs.sv ***
// Software key word and boost converter control word decoder with watchdog.
// Assumes words arrive deframed and checked, one per cycle with word_valid high.
`timescale 1ns/1ps
`default_nettype none
module sbc_regs #(
  parameter int unsigned WD_TIMEOUT_CYC = sbc_pkg::WD_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic word_valid,
  input wire sbc_pkg::sbc_word_s word_in,
  input wire logic wd_enable,
  output logic crc_check_on,
  output sbc_pkg::sbc_boost_s boost_cfg,
  output logic [3:0] boost_chan_clk,
  output sbc_pkg::sbc_slew_s [3:0] slew_cfg,
  output logic soft_reset_pulse,
  output logic alert,
  output logic keepalive_pulse,
  output logic word_ignored
);

  sbc_pkg::sbc_kind_e kind;
  logic [11:0] key;
  logic take;
  logic is_reset_key;
  logic is_keepalive;
  logic soft_rst_r;
  logic core_rst;
  logic [31:0] wd_cnt_r;
  logic wd_expire;

  function automatic sbc_pkg::sbc_kind_e word_kind(input logic [15:0] d);
    case (d[sbc_pkg::ID_MSB:sbc_pkg::ID_LSB])
      sbc_pkg::ID_SOFTWARE: word_kind = sbc_pkg::SBC_KIND_SOFTWARE;
      sbc_pkg::ID_BOOST: word_kind = sbc_pkg::SBC_KIND_BOOST;
      sbc_pkg::ID_SLEW: word_kind = sbc_pkg::SBC_KIND_SLEW;
      default: word_kind = sbc_pkg::SBC_KIND_OTHER;
    endcase
  endfunction

  // Word decode
  assign take = word_valid && ce;
  assign kind = word_kind(word_in.data);
  assign key = word_in.data[sbc_pkg::SW_KEY_MSB:0];
  assign is_reset_key = take && (kind == sbc_pkg::SBC_KIND_SOFTWARE)
                        && (key == sbc_pkg::KEY_RESET);
  assign is_keepalive = take && (kind == sbc_pkg::SBC_KIND_SOFTWARE)
                        && (key == sbc_pkg::KEY_KEEPALIVE);

  // Soft reset clears all state the cycle after the key
  assign core_rst = rst || soft_rst_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      soft_rst_r <= 1'b0;
    else if (ce)
      soft_rst_r <= is_reset_key && !soft_rst_r;
  end

  assign soft_reset_pulse = soft_rst_r;

  // CRC check enable
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      crc_check_on <= 1'b0;
    else if (take && kind == sbc_pkg::SBC_KIND_SOFTWARE && !is_reset_key)
      crc_check_on <= word_in.data[sbc_pkg::SW_CRC_BIT];
  end

  // Boost control fields, bits 12 to 7 unused
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      boost_cfg <= sbc_pkg::BOOST_RESET;
    else if (take && kind == sbc_pkg::SBC_KIND_BOOST)
    begin
      boost_cfg.comp <= word_in.data[sbc_pkg::BC_COMP_BIT];
      boost_cfg.phase <= word_in.data[sbc_pkg::BC_PHASE_LSB +: 2];
      boost_cfg.ceiling <= word_in.data[sbc_pkg::BC_CEIL_LSB +: 2];
      if (word_in.data[sbc_pkg::BC_RATE_LSB +: 2] != sbc_pkg::RATE_RESERVED)
        boost_cfg.rate <= word_in.data[sbc_pkg::BC_RATE_LSB +: 2];
    end
  end

  // Per-channel slew settings
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      slew_cfg <= {sbc_pkg::NUM_CHAN{sbc_pkg::SLEW_RESET}};
    else if (take && kind == sbc_pkg::SBC_KIND_SLEW)
    begin
      slew_cfg[word_in.chan].enable <= word_in.data[sbc_pkg::SR_EN_BIT];
      slew_cfg[word_in.chan].clk_sel <= word_in.data[sbc_pkg::SR_CLK_LSB +: 4];
      slew_cfg[word_in.chan].step <= word_in.data[sbc_pkg::SR_STEP_LSB +: 3];
    end
  end

  // Watchdog counter, held clear while disabled; parks at WD_TIMEOUT_CYC, one past the expiry count
  // Expiry lasts one cycle, so a later keep-alive can still clear the alert
  assign wd_expire = wd_enable && (wd_cnt_r == 32'(WD_TIMEOUT_CYC - 1));

  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      wd_cnt_r <= 32'h0000_0000;
    else if (ce)
    begin
      if (!wd_enable || is_keepalive)
        wd_cnt_r <= 32'h0000_0000;
      else if (wd_cnt_r < 32'(WD_TIMEOUT_CYC))
        wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
    end
  end

  // Alert is sticky; a new expiry wins over a keep-alive
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
      alert <= 1'b0;
    else if (ce)
    begin
      if (wd_expire)
        alert <= 1'b1;
      else if (is_keepalive || !wd_enable)
        alert <= 1'b0;
    end
  end

  // Event pulses
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      keepalive_pulse <= 1'b0;
      word_ignored <= 1'b0;
    end
    else if (ce)
    begin
      keepalive_pulse <= is_keepalive;
      word_ignored <= take && ((kind == sbc_pkg::SBC_KIND_OTHER)
                      || (kind == sbc_pkg::SBC_KIND_SOFTWARE && !is_reset_key
                          && !is_keepalive && key != 12'h000));
    end
  end

  sbc_clkgen u_clkgen (
    .sys_clk(sys_clk),
    .rst(core_rst),
    .ce(ce),
    .rate(boost_cfg.rate),
    .phase(boost_cfg.phase),
    .chan_clk(boost_chan_clk)
  );

endmodule // sbc_regs
`default_nettype wire

// *** verification/sbc_regs_assertions.sv ***
// Port checker for sbc_regs: word decode, pulses and watchdog alert.
// Assumes the synchronous active-high rst on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sbc_regs_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic word_valid,
  input wire sbc_pkg::sbc_word_s word_in,
  input wire logic wd_enable,
  input wire logic crc_check_on,
  input wire sbc_pkg::sbc_boost_s boost_cfg,
  input wire logic soft_reset_pulse,
  input wire logic alert,
  input wire logic keepalive_pulse,
  input wire logic word_ignored
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic tk;
  logic [2:0] hd;
  logic [11:0] key;
  assign tk = word_valid && ce && !soft_reset_pulse;
  assign hd = word_in.data[15:13];
  assign key = word_in.data[11:0];
  a_boost_fields: assert property (tk && hd == 3'h3 |=> boost_cfg.comp == $past(word_in.data[6])
    && boost_cfg.phase == $past(word_in.data[5:4]) && boost_cfg.ceiling == $past(word_in.data[1:0]))
    else $error("boost fields not loaded");
  a_rate_hold: assert property (tk && hd == 3'h3 |=> boost_cfg.rate ==
    (($past(word_in.data[3:2]) == 2'h3) ? $past(boost_cfg.rate) : $past(word_in.data[3:2])))
    else $error("switch rate wrong");
  a_crc_write: assert property (tk && hd == 3'h4 && key != 12'h555
    |=> crc_check_on == $past(word_in.data[12])) else $error("crc enable not loaded");
  a_reset_key: assert property (tk && hd == 3'h4 && key == 12'h555 |-> ##[1:2] soft_reset_pulse
    ##[0:1] (boost_cfg == sbc_pkg::BOOST_RESET && !crc_check_on)) else $error("soft reset missing");
  a_keep_pulse: assert property (tk && hd == 3'h4 && key == 12'h195
    |-> ##[1:2] keepalive_pulse) else $error("keep-alive not seen");
  a_bad_header: assert property (tk && hd != 3'h4 && hd != 3'h3 && hd != 3'h0
    |-> ##[1:2] word_ignored) else $error("unknown word not flagged");
  a_alert_cause: assert property ($rose(alert) |-> $past(wd_enable))
    else $error("alert without watchdog");
  a_alert_drop: assert property (!wd_enable && ce |=> !alert) else $error("alert while off");
endmodule // sbc_regs_assertions
bind sbc_regs sbc_regs_assertions i_sbc_regs_assertions (.sys_clk, .rst, .ce, .word_valid,
  .word_in, .wd_enable, .crc_check_on, .boost_cfg, .soft_reset_pulse, .alert, .keepalive_pulse,
  .word_ignored);
`default_nettype wire

// *** verification/sbc_host.sv ***
// Host model writing deframed words into the word port.
// Assumes tasks are called from one bench process.
`timescale 1ns/1ps
`default_nettype none
module sbc_host (
  input wire logic sys_clk,
  output logic word_valid,
  output sbc_pkg::sbc_word_s word_in
);
  initial
  begin
    word_valid = 1'b0;
    word_in = '0;
  end
  // Released lines show the inverse of the last word
  task automatic send(input logic [17:0] w);
    @(negedge sys_clk);
    word_valid = 1'b1;
    word_in = w;
    @(negedge sys_clk);
    word_valid = 1'b0;
    word_in = ~w;
  endtask
  task automatic feed(input int n, input int gap);
    repeat (n)
    begin
      send(18'h0_8195);
      repeat (gap) @(negedge sys_clk);
    end
  endtask
endmodule // sbc_host
`default_nettype wire

// *** verification/sbc_regs_tb.sv ***
// Self-checking bench of sbc_regs with a host model on the word port.
// Assumes a 40 MHz clock and a shortened watchdog timeout.
`timescale 1ns/1ps
`default_nettype none
module sbc_regs_tb;
  localparam int unsigned WD = 20;
  logic sys_clk, rst, ce, word_valid, wd_enable, crc_check_on;
  logic soft_reset_pulse, alert, keepalive_pulse, word_ignored;
  logic [3:0] boost_chan_clk;
  logic [15:0] d;
  sbc_pkg::sbc_word_s word_in;
  sbc_pkg::sbc_boost_s boost_cfg, exp_b;
  sbc_pkg::sbc_slew_s [3:0] slew_cfg;
  int error_cnt, checked;
  sbc_regs #(.WD_TIMEOUT_CYC(WD)) i_sbc_regs (.sys_clk, .rst, .ce, .word_valid, .word_in,
    .wd_enable, .crc_check_on, .boost_cfg, .boost_chan_clk, .slew_cfg, .soft_reset_pulse,
    .alert, .keepalive_pulse, .word_ignored);
  sbc_host i_sbc_host (.sys_clk, .word_valid, .word_in);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic sbc_pkg::sbc_boost_s nb(sbc_pkg::sbc_boost_s p, logic [15:0] v);
    return {v[6:4], (v[3:2] == 2'h3) ? p.rate : v[3:2], v[1:0]};
  endfunction
  function automatic logic ph_ok(logic [1:0] ph, logic [3:0] c);
    case (ph)
      2'h0: return c == 4'h0 || c == 4'hf;
      2'h1: return c[0] == c[1] && c[2] == c[3];
      2'h2: return c[0] == c[2] && c[1] == c[3];
      default: return 1'b1;
    endcase
  endfunction
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #(25 * 8000);
    error_cnt++;
    $display("mismatch at %0t: timeout", $time);
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    wd_enable = 1'b0;
    error_cnt = 0;
    checked = 0;
    d = 16'($urandom(15));
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    chk(boost_cfg === sbc_pkg::BOOST_RESET && crc_check_on === 1'b0, "reset values");
    exp_b = sbc_pkg::BOOST_RESET;
    for (int i = 0; i < 16; i++)
    begin
      wd_enable = 1'($urandom);
      d = {3'h3, 13'($urandom)};
      if (i < 4)
        d[5:0] = {i[1:0], i[1:0], i[1:0]};
      i_sbc_host.send({2'h0, d});
      exp_b = nb(exp_b, d);
      chk(boost_cfg === exp_b, "boost fields");
      for (int k = 0; k < 170; k++)
      begin
        @(negedge sys_clk);
        ce = (k == 169) || (($urandom % 4) != 0);
        chk(ph_ok(exp_b.phase, boost_chan_clk), "channel phase");
      end
    end
    wd_enable = 1'b0;
    i_sbc_host.send(18'h0_9000);
    chk(crc_check_on === 1'b1, "crc on");
    ce = 1'b0;
    i_sbc_host.send(18'h0_8000);
    ce = 1'b1;
    chk(crc_check_on === 1'b1, "word taken without enable");
    i_sbc_host.send(18'h0_8000);
    chk(crc_check_on === 1'b0, "crc off");
    i_sbc_host.send(18'h0_2abc);
    chk(word_ignored === 1'b1, "unknown header not flagged");
    i_sbc_host.send(18'h0_9123);
    chk(word_ignored === 1'b1, "odd key not flagged");
    chk(boost_cfg === exp_b && crc_check_on === 1'b1, "ignored words");
    for (int c = 0; c < 4; c++)
    begin
      d = {3'h0, 13'($urandom)};
      i_sbc_host.send({c[1:0], d});
      chk(slew_cfg[c] === {d[12], d[6:3], d[2:0]}, "slew word");
    end
    i_sbc_host.send(18'h0_9555);
    chk(soft_reset_pulse === 1'b1, "soft reset pulse");
    repeat (3) @(negedge sys_clk);
    chk(boost_cfg === sbc_pkg::BOOST_RESET && crc_check_on === 1'b0, "soft reset");
    wd_enable = 1'b1;
    i_sbc_host.feed(6, WD - 8);
    repeat (4) @(negedge sys_clk);
    chk(alert === 1'b0, "alert while fed");
    repeat (6) @(negedge sys_clk);
    chk(alert === 1'b1, "alert after timeout");
    i_sbc_host.send(18'h0_8195);
    chk(alert === 1'b0, "keep-alive clears alert");
    chk(keepalive_pulse === 1'b1, "keep-alive pulse");
    wd_enable = 1'b0;
    repeat (3 * WD) @(negedge sys_clk);
    chk(alert === 1'b0, "watchdog off");
    end_of_test();
  end
endmodule // sbc_regs_tb
`default_nettype wire
